//--- sim/pk_engine_status_flags_tb_top.sv
module pk_engine_status_flags_tb_top;
    import pk_status_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata, feed_word;
    logic        seq_jump_zero, seq_fault, seq_feed_take, fault_req = 1'b0;
    logic        feed_valid, start_pulse, engine_busy, irq_out;
    logic [31:0] st;
    int          n_fail = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          k;
    // Clock at 25 MHz
    always #20 sys_clk = ~sys_clk;
    pk_engine_status_flags i_pk_engine_status_flags (
        .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .seq_jump_zero(seq_jump_zero), .seq_fault(seq_fault),
        .seq_feed_take(seq_feed_take), .feed_word(feed_word), .feed_valid(feed_valid),
        .start_pulse(start_pulse), .engine_busy(engine_busy), .irq_out(irq_out));
    seq_model i_seq_model (
        .sys_clk(sys_clk), .rst_n(rst_n), .start_pulse(start_pulse),
        .feed_valid(feed_valid), .fault_req(fault_req), .seq_jump_zero(seq_jump_zero),
        .seq_fault(seq_fault), .seq_feed_take(seq_feed_take));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe beside address and data
    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    // One-cycle read strobe; data stand in the following cycle
    task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic fault_pulse;
        @(posedge sys_clk);
        fault_req <= 1'b1;
        @(posedge sys_clk);
        fault_req <= 1'b0;
        idle(4);
    endtask
    // Cuts a hang short
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 chk({31'h0, engine_busy}, 32'h1);
        rst_n = 1'b1;
        // Boot length and completion after reset
        k = 0;
        while (engine_busy !== 1'b0 && k < 400) begin
            @(posedge sys_clk);
            #1 k++;
        end
        chk(32'(k >= BOOT_CYCLES - 1 && k <= BOOT_CYCLES + 1), 32'h1);
        reg_read(STATUS_ADDR, st);
        chk(st & 32'h0000fff7, 32'h00000001);
        $display("test boot done");
        // Any write clears, never loads; reserved places read zero
        reg_write(STATUS_ADDR, 32'h0000001f);
        idle(1);
        reg_read(STATUS_ADDR, st);
        chk(st, 32'h0);
        $display("test clear done");
        // Unmapped read and write both flag; read data not examined
        for (int i = 0; i < 2; i++) begin
            reg_write(STATUS_ADDR, 32'h0);
            if (i == 0) reg_read(12'hb08, st);
            else reg_write(12'hb0a, 32'h5);
            idle(1);
            reg_read(STATUS_ADDR, st);
            chk(st & 32'h00000004, 32'h00000004);
        end
        $display("test range done");
        // Interrupt mirror, global enable and mask
        reg_write(STATUS_ADDR, 32'h0);
        fault_pulse();
        reg_read(STATUS_ADDR, st);
        chk(st & 32'h0000000e, 32'h0000000a);
        chk({31'h0, irq_out}, 32'h0);
        reg_write(CTRL_ADDR, 32'h10);
        idle(2);
        chk({31'h0, irq_out}, 32'h1);
        reg_read(CTRL_ADDR, st);
        chk(st, 32'h00000010);
        reg_write(MASK_ADDR, 32'h2);
        reg_read(MASK_ADDR, st);
        chk(st, 32'h00000002);
        reg_write(STATUS_ADDR, 32'h0);
        fault_pulse();
        reg_read(STATUS_ADDR, st);
        chk(st & 32'h0000000a, 32'h00000002);
        chk({31'h0, irq_out}, 32'h0);
        $display("test irq done");
        // Double-buffered feed through a run
        reg_write(MASK_ADDR, 32'h7);
        reg_write(FEED_ADDR, 32'h11112222);
        reg_write(FEED_ADDR, 32'h33334444);
        reg_write(STATUS_ADDR, 32'h0);
        reg_write(CTRL_ADDR, 32'h18);
        #1 chk({30'h0, start_pulse, engine_busy}, 32'h3);
        reg_read(CTRL_ADDR, st);
        chk(st, 32'h00000018);
        k = 0;
        st = 32'h0;
        while (st[FEED_RDY_BIT] !== 1'b1 && k < 40) begin
            reg_read(STATUS_ADDR, st);
            k++;
        end
        chk(st & 32'h00000010, 32'h00000010);
        chk(feed_word, 32'h33334444);
        chk({31'h0, feed_valid}, 32'h1);
        idle(2);
        chk({31'h0, irq_out}, 32'h1);
        reg_write(FEED_ADDR, 32'h55556666);
        idle(2);
        chk({31'h0, irq_out}, 32'h0);
        reg_read(STATUS_ADDR, st);
        chk(st & 32'h00000010, 32'h0);
        k = 0;
        while (engine_busy !== 1'b0 && k < 100) begin
            idle(1);
            k++;
        end
        reg_read(STATUS_ADDR, st);
        chk(st & 32'h00000001, 32'h00000001);
        chk({31'h0, irq_out}, 32'h0);
        $display("test feed done");
        // Feed-ready masked for a second run: flag still sets, pin stays low
        reg_write(MASK_ADDR, 32'h17);
        reg_write(STATUS_ADDR, 32'h0);
        reg_write(CTRL_ADDR, 32'h18);
        idle(20);
        reg_read(STATUS_ADDR, st);
        chk(st & 32'h00000018, 32'h00000010);
        chk(feed_word, 32'h55556666);
        chk({31'h0, irq_out}, 32'h0);
        k = 0;
        while (engine_busy !== 1'b0 && k < 100) begin
            idle(1);
            k++;
        end
        $display("test masked feed done");
        complete_run();
    end
endmodule

//--- sim/seq_model.sv
module seq_model (
    input  wire logic sys_clk,       // Engine clock
    input  wire logic rst_n,         // Reset, active low
    input  wire logic start_pulse,   // Start from the engine
    input  wire logic feed_valid,    // Active feed word present
    input  wire logic fault_req,     // Bench asks for one fault pulse
    output logic      seq_jump_zero, // Routine ended at address zero
    output logic      seq_fault,     // General error pulse
    output logic      seq_feed_take  // Consumes the active feed word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic running_r;
    int   cnt_r;
    // Fixed-length routine: takes one word at count 10, ends with a jump to zero at count 40
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            running_r     <= 1'b0;
            cnt_r         <= 0;
            seq_jump_zero <= 1'b0;
            seq_fault     <= 1'b0;
            seq_feed_take <= 1'b0;
        end else begin
            seq_jump_zero <= 1'b0;
            seq_feed_take <= 1'b0;
            seq_fault     <= fault_req;
            if (start_pulse) begin
                running_r <= 1'b1;
                cnt_r     <= 0;
            end else if (running_r) begin
                cnt_r <= cnt_r + 1;
                if (cnt_r == 10 && feed_valid) seq_feed_take <= 1'b1;
                if (cnt_r == 40) begin
                    seq_jump_zero <= 1'b1;
                    running_r     <= 1'b0;
                end
            end
        end
    end
endmodule

//--- src/feed_buffer.sv
module feed_buffer (
    input  wire logic      sys_clk, // Engine clock
    input  wire logic      rst_n,   // Asynchronous reset, active low
    feed_if.buffer_side    fb       // Host writes in, sequencer takes out
);
    logic [31:0] hold_r;
    logic        hold_full_r;
    logic [31:0] active_r;
    logic        active_valid_r;
    logic        move;

    // Holding word advances when the active slot is empty or being consumed
    assign move = hold_full_r && (!active_valid_r || fb.take);

    // Holding slot, filled by host writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r      <= 32'h0;
            hold_full_r <= 1'b0;
        end else if (fb.wr) begin
            hold_r      <= fb.wdata;
            hold_full_r <= 1'b1;
        end else if (move) begin
            hold_full_r <= 1'b0;
        end
    end

    // Active slot, read by the sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_r       <= 32'h0;
            active_valid_r <= 1'b0;
        end else if (move) begin
            active_r       <= hold_r;
            active_valid_r <= 1'b1;
        end else if (fb.take) begin
            active_valid_r <= 1'b0;
        end
    end

    // A slot frees up and the host has not refilled it in the same cycle
    assign fb.ready_pulse = (move || (fb.take && active_valid_r)) && !fb.wr;
    assign fb.word        = active_r;
    assign fb.valid       = active_valid_r;

    a_hold_fills: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fb.wr |=> hold_full_r && hold_r == $past(fb.wdata))
        else $error("feed word not held");
    a_hold_moves: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (hold_full_r && !active_valid_r) |=> active_valid_r && active_r == $past(hold_r))
        else $error("held feed word not advanced");
endmodule

//--- src/feed_if.sv
interface feed_if;
    logic [31:0] wdata;
    logic        wr;
    logic        take;
    logic [31:0] word;
    logic        valid;
    logic        ready_pulse;
    modport host_side   (output wdata, wr, take, input word, valid, ready_pulse);
    modport buffer_side (input wdata, wr, take, output word, valid, ready_pulse);
endinterface

//--- src/pk_engine_status_flags.sv
// Notes on behaviour
// - After start, next jump to zero flags.
// - Any status write clears, never loads.
// - Feed-ready bit set when word accepted.
// - Feed write clears feed-ready; interrupt too if no other unmasked event pends.
// - Interrupt drops two cycles after feed write.
// - Feed port double-buffered; host refills in time.
// - Interrupt bit mirrors pin, ignores enable.
// - Unknown address access sets out-of-range.
// - Out-of-range read data is zero.
// - General fault bit for other errors.
// - Jump to address zero sets completion.
// - Busy booting; completion set when ready.
// - Errors set their status bit to one.
// - Enable low holds interrupt pin low.
// - Masked status bit causes no interrupt.
module pk_engine_status_flags
    import pk_status_pkg::*;
(
    input  wire logic        sys_clk,       // Engine clock, 25 MHz
    input  wire logic        rst_n,         // Asynchronous reset, active low
    input  wire logic [11:0] reg_addr,      // Register address
    input  wire logic [31:0] reg_wdata,     // Register write data
    input  wire logic        reg_wr,        // Write strobe
    input  wire logic        reg_rd,        // Read strobe
    output logic      [31:0] reg_rdata,     // Read data, cycle after strobe
    input  wire logic        seq_jump_zero, // Sequencer branched to address zero
    input  wire logic        seq_fault,     // Sequencer general error pulse
    input  wire logic        seq_feed_take, // Sequencer consumes active feed word
    output logic      [31:0] feed_word,     // Active multiplier word
    output logic             feed_valid,    // Active multiplier word present
    output logic             start_pulse,   // One-cycle start to sequencer
    output logic             engine_busy,   // Boot or run in progress
    output logic             irq_out        // Interrupt pin, active high
);
    // Sequencing state and boot timer
    eng_state_type state_r;
    eng_state_type state_nxt;
    logic [15:0]   boot_cnt_r;
    // Status, control and mask storage
    logic [15:0]   event_r;
    logic [15:0]   event_nxt;
    logic [15:0]   ctrl_r;
    logic [15:0]   mask_r;
    logic          irq_cond;
    logic          irq_cond_r;
    logic          irq_r;
    // Host port decode and event vectors
    logic          ctrl_wr;
    logic          status_wr;
    logic          mask_wr;
    logic          feed_wr;
    logic          oor_access;
    logic          boot_end;
    logic          start_req;
    logic [15:0]   set_vec;
    logic [15:0]   clr_vec;
    logic [15:0]   status_view;
    logic [31:0]   rdata_r;

    feed_if fport ();

    // True for every address that holds a register
    function automatic logic is_mapped(input logic [11:0] addr);
        return (addr == CTRL_ADDR) || (addr == STATUS_ADDR) ||
               (addr == MASK_ADDR) || (addr == FEED_ADDR);
    endfunction

    // Address decode of host strobes
    assign ctrl_wr    = reg_wr && (reg_addr == CTRL_ADDR);
    assign status_wr  = reg_wr && (reg_addr == STATUS_ADDR);
    assign mask_wr    = reg_wr && (reg_addr == MASK_ADDR);
    assign feed_wr    = reg_wr && (reg_addr == FEED_ADDR);
    assign oor_access = (reg_wr || reg_rd) && !is_mapped(reg_addr);
    assign start_req  = ctrl_wr && reg_wdata[CTRL_START_BIT] && (state_r == ST_IDLE);

    // Double-buffered multiplier feed
    assign fport.wdata = reg_wdata;
    assign fport.wr    = feed_wr;
    assign fport.take  = seq_feed_take;

    feed_buffer i_feed_buffer (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .fb      (fport)
    );

    assign feed_word  = fport.word;
    assign feed_valid = fport.valid;

    // Boot routine timer, runs once after reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_cnt_r <= 16'h0;
        end else if (state_r == ST_BOOT) begin
            boot_cnt_r <= boot_cnt_r + 16'h1;
        end
    end

    assign boot_end = (state_r == ST_BOOT) && (boot_cnt_r == BOOT_LAST);

    // Engine sequencing state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_BOOT: begin
                if (boot_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (start_req) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (seq_jump_zero) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_BOOT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Start command pulse towards the sequencer
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= start_req;
        end
    end

    assign engine_busy = (state_r != ST_IDLE);

    // Event sources; each sets its own status bit
    always_comb begin
        set_vec               = 16'h0;
        set_vec[DONE_BIT]     = boot_end || (seq_jump_zero && state_r != ST_BOOT);
        set_vec[FAULT_BIT]    = seq_fault;
        set_vec[OOR_BIT]      = oor_access;
        set_vec[FEED_RDY_BIT] = fport.ready_pulse;
    end

    // Status writes clear everything; feed writes clear the feed-ready bit
    always_comb begin
        clr_vec = 16'h0;
        if (status_wr) begin
            clr_vec = EVENT_BITS;
        end
        if (feed_wr) begin
            clr_vec[FEED_RDY_BIT] = 1'b1;
        end
    end

    // Sticky status events, set wins over clear, write data never loaded
    assign event_nxt = ((event_r & ~clr_vec) | set_vec) & EVENT_BITS;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            event_r <= EVENT_RESET;
        end else begin
            event_r <= event_nxt;
        end
    end

    // Control and mask registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_r[CTRL_IRQ_EN_BIT] <= reg_wdata[CTRL_IRQ_EN_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= MASK_RESET;
        end else if (mask_wr) begin
            mask_r <= reg_wdata[15:0] & MASK_WMASK;
        end
    end

    // Unmasked pending events, independent of the global enable
    assign irq_cond = |(event_r & ~mask_r);

    // Mirror bit and pin both registered from the same term
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_cond_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            irq_cond_r <= irq_cond;
            irq_r      <= irq_cond && ctrl_r[CTRL_IRQ_EN_BIT];
        end
    end

    assign irq_out = irq_r;

    // Status as seen by the host
    always_comb begin
        status_view          = event_r;
        status_view[IRQ_BIT] = irq_cond_r;
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                CTRL_ADDR: begin
                    rdata_r <= {16'h0, 11'h0, ctrl_r[CTRL_IRQ_EN_BIT],
                                (state_r == ST_RUN), 3'h0};
                end
                STATUS_ADDR: begin
                    rdata_r <= {16'h0, status_view};
                end
                MASK_ADDR: begin
                    rdata_r <= {16'h0, mask_r};
                end
                default: begin
                    rdata_r <= 32'h0;
                end
            endcase
        end else begin
            rdata_r <= 32'h0;
        end
    end

    assign reg_rdata = rdata_r;

    // Sequences used by the checks below
    sequence feed_only_pending;
        feed_wr && !status_wr && !fport.ready_pulse && !oor_access &&
        ((event_r & ~mask_r) == (16'h1 << FEED_RDY_BIT));
    endsequence

    sequence quiet_pair;
        (set_vec == 16'h0) [*2];
    endsequence

    sequence started_run;
        start_req ##1 (state_r == ST_RUN);
    endsequence

    a_done_on_jump: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (seq_jump_zero && state_r != ST_BOOT) |=> event_r[DONE_BIT])
        else $error("completion not flagged on jump to zero");

    a_run_then_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        started_run ##[0:200] (seq_jump_zero && state_r == ST_RUN)
        |=> event_r[DONE_BIT] && state_r == ST_IDLE)
        else $error("run end not flagged");

    a_write_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (status_wr && set_vec == 16'h0) |=> (event_r == 16'h0))
        else $error("status write did not clear");

    a_write_no_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        status_wr |=> ((event_r & ~$past(set_vec)) == 16'h0))
        else $error("status write loaded data");

    a_ready_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        fport.ready_pulse |=> event_r[FEED_RDY_BIT])
        else $error("feed-ready not set");

    a_feed_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (feed_wr && !fport.ready_pulse) |=> !event_r[FEED_RDY_BIT])
        else $error("feed write left feed-ready set");

    a_irq_latency: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (feed_only_pending ##1 quiet_pair) |-> !irq_r)
        else $error("interrupt not dropped two cycles after feed write");

    a_irq_mirror: assert property (@(posedge sys_clk) disable iff (!rst_n)
        irq_cond |=> status_view[IRQ_BIT] && (irq_r == ctrl_r[CTRL_IRQ_EN_BIT] || $past(ctrl_wr)))
        else $error("interrupt bit not mirrored");

    a_oor_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        oor_access |=> event_r[OOR_BIT])
        else $error("out-of-range access not flagged");

    a_fault_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_fault |=> event_r[FAULT_BIT])
        else $error("general fault not flagged");

    a_boot_busy: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_BOOT && !boot_end) |=> !event_r[DONE_BIT] && engine_busy)
        else $error("completion during boot");

    a_boot_done: assert property (@(posedge sys_clk) disable iff (!rst_n)
        boot_end |=> event_r[DONE_BIT] && !engine_busy)
        else $error("boot end not flagged");

    a_enable_gates: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !ctrl_r[CTRL_IRQ_EN_BIT] |=> !irq_out)
        else $error("interrupt pin high while disabled");

    a_mask_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((event_r & ~mask_r) == 16'h0) |=> !irq_out && !status_view[IRQ_BIT])
        else $error("masked bit raised interrupt");

    a_irq_raised: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (irq_cond && ctrl_r[CTRL_IRQ_EN_BIT]) |=> irq_out)
        else $error("interrupt pin not raised");

    // Further checks on start, mirror, decode and readback
    a_start_from_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_wr && reg_wdata[CTRL_START_BIT] && state_r == ST_IDLE)
        |=> start_pulse && state_r == ST_RUN)
        else $error("start command not taken while idle");

    a_run_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_RUN && !seq_jump_zero) |=> state_r == ST_RUN && engine_busy)
        else $error("run ended without jump to zero");

    a_mirror_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (irq_cond && !ctrl_r[CTRL_IRQ_EN_BIT]) |=> status_view[IRQ_BIT] && !irq_out)
        else $error("interrupt bit not set while disabled");

    a_fault_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (event_r[FAULT_BIT] && !status_wr) |=> event_r[FAULT_BIT])
        else $error("fault bit lost without status write");

    a_mapped_no_oor: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ((reg_wr || reg_rd) && is_mapped(reg_addr) && !event_r[OOR_BIT]) |=> !event_r[OOR_BIT])
        else $error("mapped access flagged out of range");

    a_status_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_rd && reg_addr == STATUS_ADDR) |=> reg_rdata == {16'h0, $past(status_view)})
        else $error("status read data wrong");
endmodule

//--- src/pk_status_pkg.sv
package pk_status_pkg;
    // Register offsets on the host port
    localparam logic [11:0] CTRL_ADDR     = 12'hb00;
    localparam logic [11:0] STATUS_ADDR   = 12'hb02;
    localparam logic [11:0] MASK_ADDR     = 12'hb04;
    localparam logic [11:0] FEED_ADDR     = 12'hb06;
    // Status field positions, counted from the least significant bit
    localparam int          DONE_BIT      = 0;
    localparam int          FAULT_BIT     = 1;
    localparam int          OOR_BIT       = 2;
    localparam int          IRQ_BIT       = 3;
    localparam int          FEED_RDY_BIT  = 4;
    // Control field positions
    localparam int          CTRL_START_BIT  = 3;
    localparam int          CTRL_IRQ_EN_BIT = 4;
    // Reset values and writable fields
    localparam logic [15:0] STATUS_RESET  = 16'h0001;
    localparam logic [15:0] EVENT_RESET   = 16'h0000;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [15:0] MASK_RESET    = 16'h0000;
    localparam logic [15:0] EVENT_BITS    = 16'h0017;
    localparam logic [15:0] MASK_WMASK    = 16'h0017;
    // Boot routine length
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          BOOT_TIME_NS  = 10240;
    localparam int          BOOT_CYCLES   = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] BOOT_LAST     = 16'(BOOT_CYCLES - 1);
    // Engine sequencing states
    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_IDLE = 2'b01,
        ST_RUN  = 2'b10
    } eng_state_type;
endpackage
